// ### hdl/auss_pkg.sv
package auss_pkg;

	// ***************************************************************
	// register byte offsets
	// ***************************************************************
	localparam logic [5:0] ADR_CMD     = 6'h00;
	localparam logic [5:0] ADR_FEAT    = 6'h04;
	localparam logic [5:0] ADR_SCNT    = 6'h08;
	localparam logic [5:0] ADR_SNUM    = 6'h0c;
	localparam logic [5:0] ADR_CYL_LO  = 6'h10;
	localparam logic [5:0] ADR_CYL_HI  = 6'h14;
	localparam logic [5:0] ADR_DEVHEAD = 6'h18;
	localparam logic [5:0] ADR_DATA    = 6'h1c;
	localparam logic [5:0] ADR_STATUS  = 6'h20;
	localparam logic [5:0] ADR_CTRL    = 6'h24;
	localparam logic [5:0] ADR_MODE    = 6'h28;

	// ***************************************************************
	// opcodes and subcommands
	// ***************************************************************
	localparam logic [7:0] OP_UNLOCK   = 8'hf2;
	localparam logic [7:0] OP_ERASE    = 8'hf4;
	localparam logic [7:0] OP_SETFEAT  = 8'hef;
	localparam logic [3:0] OP_SEEK_HI  = 4'h7;

	localparam logic [7:0] SF_8BIT_ON  = 8'h01;
	localparam logic [7:0] SF_8BIT_OFF = 8'h81;
	localparam logic [7:0] SF_WC_ON    = 8'h02;
	localparam logic [7:0] SF_WC_OFF   = 8'h82;
	localparam logic [7:0] SF_XFER     = 8'h03;
	localparam logic [7:0] SF_APM_ON   = 8'h05;
	localparam logic [7:0] SF_APM_OFF  = 8'h85;
	localparam logic [7:0] SF_EXT_ON   = 8'h09;
	localparam logic [7:0] SF_EXT_OFF  = 8'h89;
	localparam logic [7:0] SF_PL1_ON   = 8'h0a;
	localparam logic [7:0] SF_PL1_OFF  = 8'h8a;
	localparam logic [7:0] SF_RLA_OFF  = 8'h55;
	localparam logic [7:0] SF_RLA_ON   = 8'haa;
	localparam logic [7:0] SF_POR_OFF  = 8'h66;
	localparam logic [7:0] SF_POR_ON   = 8'hcc;
	localparam logic [7:0] SF_NOP_A    = 8'h69;
	localparam logic [7:0] SF_NOP_B    = 8'h96;
	localparam logic [7:0] SF_COMPAT   = 8'h97;
	localparam logic [7:0] SF_CURSRC   = 8'h9a;
	localparam logic [7:0] SF_LONG4    = 8'hbb;

	// ***************************************************************
	// transfer type codes, levels, counts
	// ***************************************************************
	localparam logic [4:0] XT_PIO_DEF  = 5'h00;
	localparam logic [4:0] XT_PIO_FC   = 5'h01;
	localparam logic [4:0] XT_MDMA     = 5'h04;
	localparam logic [4:0] XT_UDMA     = 5'h08;
	localparam logic [2:0] XM_DEF      = 3'h0;
	localparam logic [2:0] XM_NOIORDY  = 3'h1;
	localparam logic [2:0] PIO_IORDY   = 3'h3;
	localparam logic [7:0] APM_MIN     = 8'h01;
	localparam logic [7:0] APM_MAX     = 8'hfe;
	localparam logic [2:0] UNLOCK_INIT = 3'h5;
	localparam logic [7:0] PW_FIRST    = 8'h01;
	localparam logic [7:0] PW_LAST     = 8'h10;
	localparam logic [7:0] SECT_LAST   = 8'hff;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [2:0] PIO_RST     = 3'h0;
	localparam logic [2:0] DMA_RST     = 3'h0;
	localparam logic       WC_RST      = 1'b1;
	localparam logic       RLA_RST     = 1'b1;
	localparam logic       POR_RST     = 1'b1;
	localparam logic [7:0] CUR_RST     = 8'hff;

	// ***************************************************************
	// status and control bit positions
	// ***************************************************************
	localparam int ST_BUSY  = 0;
	localparam int ST_DRQ   = 1;
	localparam int ST_ERR   = 2;
	localparam int ST_ABRT  = 3;
	localparam int ST_IDNF  = 4;
	localparam int ST_LOCK  = 5;
	localparam int ST_LMAX  = 6;
	localparam int ST_CNT   = 8;
	localparam int CT_LOCK  = 0;
	localparam int CT_LMAX  = 1;

	typedef enum logic [1:0] {
		AUSS_IDLE  = 2'b00,
		AUSS_XFER  = 2'b01,
		AUSS_EVAL  = 2'b11,
		AUSS_FLUSH = 2'b10
	} auss_state_t;

endpackage

// ### hdl/auss_core.sv
`timescale 1ns/1ps

module auss_core
	import auss_pkg::*;
#(
	parameter int          PIO_MAX   = 4,
	parameter int          MDMA_MAX  = 2,
	parameter int          UDMA_MAX  = 4,
	parameter bit          DMA_OK    = 1'b1,
	parameter bit          NOIORDY   = 1'b1,
	parameter logic [27:0] LBA_TOTAL = 28'h0400000,
	parameter logic [15:0] CYL_TOTAL = 16'h3fff,
	parameter logic [3:0]  HEAD_MAX  = 4'hf,
	parameter logic [7:0]  CUR_LOW   = 8'h01,
	parameter logic [7:0]  CUR_HIGH  = 8'hff
)(
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [5:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	input  wire logic [255:0]  user_pw_i,
	input  wire logic [255:0]  master_pw_i,
	input  wire logic          flush_done_i,
	output logic [31:0]        wb_dat_o,
	output logic               wb_ack_o,
	output logic               iordy_en_o,
	output logic               io16_en_o,
	output logic               wcache_en_o,
	output logic               flush_req_o,
	output logic               apm_en_o,
	output logic [7:0]         apm_level_o,
	output logic               udma_sel_o,
	output logic [2:0]         dma_mode_o,
	output logic [2:0]         pio_mode_o
);

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		auss_state_t fsm;
		logic        ack;
		logic [31:0] rdat;
		logic [7:0]  cmd;
		logic [7:0]  feat;
		logic [7:0]  scnt;
		logic [7:0]  snum;
		logic [7:0]  cyl_lo;
		logic [7:0]  cyl_hi;
		logic [7:0]  devhead;
		logic        busy;
		logic        drq;
		logic        err;
		logic        abrt;
		logic        idnf;
		logic        locked;
		logic        lvl_max;
		logic [2:0]  tries;
		logic [7:0]  wcnt;
		logic        ident;
		logic        mism_u;
		logic        mism_m;
		logic [2:0]  pio;
		logic        noiordy;
		logic        udma;
		logic [2:0]  dma;
		logic        mode8;
		logic        wcache;
		logic        flush;
		logic        apm;
		logic [7:0]  apm_lvl;
		logic        rla;
		logic        por;
		logic [7:0]  cur_src;
		logic        iordy;
	} auss_regs_t;

	auss_regs_t st_reg;
	auss_regs_t st_next;

	// ***************************************************************
	// helpers
	// ***************************************************************
	function automatic logic [15:0] pw_word(input logic [255:0] pw,
		input logic [3:0] idx);
		pw_word = pw[{idx, 4'h0} +: 16];
	endfunction

	function automatic logic mode_ok(input logic [2:0] m, input int top);
		mode_ok = (32'(m) <= top);
	endfunction

	logic        wb_go;
	logic        wr_go;
	logic [7:0]  wm1;
	logic [27:0] seek_lba;
	logic [15:0] seek_cyl;
	logic [4:0]  xtype;
	logic [2:0]  xmode;

	always_comb
	begin
		wb_go    = wb_cyc_i && wb_stb_i && !st_reg.ack;
		wr_go    = wb_go && wb_we_i;
		wm1      = st_reg.wcnt - PW_FIRST;
		seek_lba = {st_reg.devhead[3:0], st_reg.cyl_hi, st_reg.cyl_lo,
			st_reg.snum};
		seek_cyl = {st_reg.cyl_hi, st_reg.cyl_lo};
		xtype    = st_reg.scnt[7:3];
		xmode    = st_reg.scnt[2:0];
	end

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb
	begin
		st_next       = st_reg;
		st_next.ack   = wb_go;
		st_next.rdat  = 32'h0000_0000;

		// bus reads
		if (wb_go && !wb_we_i)
		begin
			unique case (wb_adr_i)
				ADR_FEAT:    st_next.rdat = {24'h000000, st_reg.feat};
				ADR_SCNT:    st_next.rdat = {24'h000000, st_reg.scnt};
				ADR_SNUM:    st_next.rdat = {24'h000000, st_reg.snum};
				ADR_CYL_LO:  st_next.rdat = {24'h000000, st_reg.cyl_lo};
				ADR_CYL_HI:  st_next.rdat = {24'h000000, st_reg.cyl_hi};
				ADR_DEVHEAD: st_next.rdat = {24'h000000, st_reg.devhead};
				ADR_CMD:     st_next.rdat = {24'h000000, st_reg.cmd};
				ADR_STATUS:
				begin
					st_next.rdat[ST_BUSY] = st_reg.busy;
					st_next.rdat[ST_DRQ]  = st_reg.drq;
					st_next.rdat[ST_ERR]  = st_reg.err;
					st_next.rdat[ST_ABRT] = st_reg.abrt;
					st_next.rdat[ST_IDNF] = st_reg.idnf;
					st_next.rdat[ST_LOCK] = st_reg.locked;
					st_next.rdat[ST_LMAX] = st_reg.lvl_max;
					st_next.rdat[ST_CNT +: 3] = st_reg.tries;
				end
				ADR_CTRL:
				begin
					st_next.rdat[CT_LOCK] = st_reg.locked;
					st_next.rdat[CT_LMAX] = st_reg.lvl_max;
				end
				ADR_MODE:
					st_next.rdat = {st_reg.cur_src, st_reg.apm_lvl, 3'h0,
						st_reg.por, st_reg.rla, st_reg.apm, st_reg.wcache,
						st_reg.mode8, st_reg.noiordy, st_reg.udma,
						st_reg.dma, st_reg.pio};
				default:     st_next.rdat = 32'h0000_0000;
			endcase
		end

		// task file writes while idle
		if (wr_go && wb_sel_i[0] && !st_reg.busy)
		begin
			unique case (wb_adr_i)
				ADR_FEAT:    st_next.feat    = wb_dat_i[7:0];
				ADR_SCNT:    st_next.scnt    = wb_dat_i[7:0];
				ADR_SNUM:    st_next.snum    = wb_dat_i[7:0];
				ADR_CYL_LO:  st_next.cyl_lo  = wb_dat_i[7:0];
				ADR_CYL_HI:  st_next.cyl_hi  = wb_dat_i[7:0];
				ADR_DEVHEAD: st_next.devhead = wb_dat_i[7:0];
				default:     st_next.feat    = st_reg.feat;
			endcase
		end

		// ***********************************************************
		// command sequencer
		// ***********************************************************
		unique case (st_reg.fsm)
			AUSS_IDLE:
			begin
				if (wr_go && wb_sel_i[0] && wb_adr_i == ADR_CMD)
				begin
					st_next.cmd  = wb_dat_i[7:0];
					st_next.err  = 1'b0;
					st_next.abrt = 1'b0;
					st_next.idnf = 1'b0;
					if (wb_dat_i[7:0] == OP_UNLOCK)
					begin
						if (st_reg.tries == 3'h0)
						begin
							st_next.err  = 1'b1;
							st_next.abrt = 1'b1;
						end
						else
						begin
							st_next.busy   = 1'b1;
							st_next.drq    = 1'b1;
							st_next.wcnt   = 8'h00;
							st_next.mism_u = 1'b0;
							st_next.mism_m = 1'b0;
							st_next.fsm    = AUSS_XFER;
						end
					end
					else if (wb_dat_i[7:4] == OP_SEEK_HI)
					begin
						if (st_reg.devhead[6] ? (seek_lba >= LBA_TOTAL)
							: (seek_cyl >= CYL_TOTAL ||
							st_reg.devhead[3:0] > HEAD_MAX))
						begin
							st_next.err  = 1'b1;
							st_next.idnf = 1'b1;
						end
					end
					else if (wb_dat_i[7:0] == OP_SETFEAT)
					begin
						unique case (st_reg.feat)
							SF_8BIT_ON:  st_next.mode8 = 1'b1;
							SF_8BIT_OFF: st_next.mode8 = 1'b0;
							SF_WC_ON:    st_next.wcache = 1'b1;
							SF_WC_OFF:
							begin
								st_next.wcache = 1'b0;
								st_next.flush  = 1'b1;
								st_next.busy   = 1'b1;
								st_next.fsm    = AUSS_FLUSH;
							end
							SF_XFER:
							begin
								if (xtype == XT_PIO_DEF && xmode == XM_DEF)
								begin
									st_next.pio     = PIO_RST;
									st_next.noiordy = 1'b0;
								end
								else if (xtype == XT_PIO_DEF &&
									xmode == XM_NOIORDY && NOIORDY)
								begin
									st_next.pio     = PIO_RST;
									st_next.noiordy = 1'b1;
								end
								else if (xtype == XT_PIO_FC &&
									mode_ok(xmode, PIO_MAX))
								begin
									st_next.pio     = xmode;
									st_next.noiordy = 1'b0;
								end
								else if (xtype == XT_MDMA && DMA_OK &&
									mode_ok(xmode, MDMA_MAX))
								begin
									st_next.udma = 1'b0;
									st_next.dma  = xmode;
								end
								else if (xtype == XT_UDMA && DMA_OK &&
									mode_ok(xmode, UDMA_MAX))
								begin
									st_next.udma = 1'b1;
									st_next.dma  = xmode;
								end
								else
								begin
									st_next.err  = 1'b1;
									st_next.abrt = 1'b1;
								end
							end
							SF_APM_ON:
							begin
								if (st_reg.scnt >= APM_MIN &&
									st_reg.scnt <= APM_MAX)
								begin
									st_next.apm     = 1'b1;
									st_next.apm_lvl = st_reg.scnt;
								end
								else
								begin
									st_next.err  = 1'b1;
									st_next.abrt = 1'b1;
								end
							end
							SF_APM_OFF:  st_next.apm = 1'b0;
							SF_RLA_OFF:  st_next.rla = 1'b0;
							SF_RLA_ON:   st_next.rla = 1'b1;
							SF_POR_OFF:  st_next.por = 1'b0;
							SF_POR_ON:   st_next.por = 1'b1;
							SF_CURSRC:
							begin
								st_next.cur_src = st_reg.scnt;
								st_next.cyl_lo  = CUR_LOW;
								st_next.cyl_hi  = CUR_HIGH;
							end
							SF_NOP_A, SF_NOP_B, SF_COMPAT: ;
							SF_EXT_ON, SF_EXT_OFF, SF_PL1_ON,
							SF_PL1_OFF, SF_LONG4: ;
							default:
							begin
								st_next.err  = 1'b1;
								st_next.abrt = 1'b1;
							end
						endcase
					end
					else
					begin
						// erase unit and unknown opcodes are refused here
						st_next.err  = 1'b1;
						st_next.abrt = 1'b1;
					end
				end
			end
			AUSS_XFER:
			begin
				if (wr_go && wb_adr_i == ADR_DATA && wb_sel_i[1:0] == 2'h3)
				begin
					if (st_reg.wcnt == 8'h00)
						st_next.ident = wb_dat_i[0];
					else if (st_reg.wcnt <= PW_LAST)
					begin
						if (wb_dat_i[15:0] != pw_word(user_pw_i, wm1[3:0]))
							st_next.mism_u = 1'b1;
						if (wb_dat_i[15:0] != pw_word(master_pw_i, wm1[3:0]))
							st_next.mism_m = 1'b1;
					end
					st_next.wcnt = st_reg.wcnt + 8'h01;
					if (st_reg.wcnt == SECT_LAST)
					begin
						st_next.drq = 1'b0;
						st_next.fsm = AUSS_EVAL;
					end
				end
			end
			AUSS_EVAL:
			begin
				st_next.busy = 1'b0;
				st_next.fsm  = AUSS_IDLE;
				if (!st_reg.locked)
					st_next.tries = st_reg.tries;
				else if (st_reg.ident && st_reg.lvl_max)
				begin
					st_next.err  = 1'b1;
					st_next.abrt = 1'b1;
				end
				else if (st_reg.ident ? st_reg.mism_m : st_reg.mism_u)
				begin
					st_next.err   = 1'b1;
					st_next.abrt  = 1'b1;
					st_next.tries = st_reg.tries - 3'h1;
				end
				else
					st_next.locked = 1'b0;
			end
			AUSS_FLUSH:
			begin
				if (flush_done_i)
				begin
					st_next.flush = 1'b0;
					st_next.busy  = 1'b0;
					st_next.fsm   = AUSS_IDLE;
				end
			end
		endcase

		// control register; a lock set beats an unlock clear
		if (wr_go && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
		begin
			if (wb_dat_i[CT_LOCK])
				st_next.locked = 1'b1;
			st_next.lvl_max = wb_dat_i[CT_LMAX];
		end

		st_next.iordy = (st_next.pio >= PIO_IORDY) || !st_next.noiordy;
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg         <= '0;
			st_reg.fsm     <= AUSS_IDLE;
			st_reg.tries   <= UNLOCK_INIT;
			st_reg.pio     <= PIO_RST;
			st_reg.dma     <= DMA_RST;
			st_reg.wcache  <= WC_RST;
			st_reg.rla     <= RLA_RST;
			st_reg.por     <= POR_RST;
			st_reg.cur_src <= CUR_RST;
			st_reg.iordy   <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	always_comb
	begin
		wb_dat_o    = st_reg.rdat;
		wb_ack_o    = st_reg.ack;
		iordy_en_o  = st_reg.iordy;
		io16_en_o   = !st_reg.mode8;
		wcache_en_o = st_reg.wcache;
		flush_req_o = st_reg.flush;
		apm_en_o    = st_reg.apm;
		apm_level_o = st_reg.apm_lvl;
		udma_sel_o  = st_reg.udma;
		dma_mode_o  = st_reg.dma;
		pio_mode_o  = st_reg.pio;
	end

endmodule

// ### testbench/auss_cache_model.sv
`timescale 1ns/1ps
// ********************
// cache flush responder
// ********************
module auss_cache_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       flush_req_i,
	input  wire logic [7:0] delay_i,
	output logic            flush_done_o
);
	logic [7:0] cnt_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !flush_req_i)
		begin
			cnt_reg <= 8'h00;
			flush_done_o <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_reg + 8'h01;
			flush_done_o <= (cnt_reg >= delay_i);
		end
	end
endmodule

// ### testbench/auss_core_monitor.sv
`timescale 1ns/1ps
// ********************
// bus and mode checks
// ********************
module auss_core_monitor
	import auss_pkg::*;
#(
	parameter int PIO_MAX  = 4,
	parameter int MDMA_MAX = 2,
	parameter int UDMA_MAX = 4
)(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        flush_done_i,
	input wire logic        wb_ack_o,
	input wire logic        iordy_en_o,
	input wire logic        io16_en_o,
	input wire logic        flush_req_o,
	input wire logic        apm_en_o,
	input wire logic [7:0]  apm_level_o,
	input wire logic        udma_sel_o,
	input wire logic [2:0]  dma_mode_o,
	input wire logic [2:0]  pio_mode_o
);
	logic sf_wr;

	assign sf_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
		&& wb_adr_i == ADR_CMD && wb_dat_i[7:0] == OP_SETFEAT;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_fl_wait;
		flush_req_o && !flush_done_i;
	endsequence

	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack;
	endproperty
	property p_iordy;
		pio_mode_o >= PIO_IORDY |-> iordy_en_o;
	endproperty
	property p_fl_hold;
		s_fl_wait |=> flush_req_o;
	endproperty
	property p_fl_drop;
		flush_req_o && flush_done_i |=> !flush_req_o;
	endproperty
	property p_pio;
		pio_mode_o <= PIO_MAX;
	endproperty
	property p_dma;
		udma_sel_o ? dma_mode_o <= UDMA_MAX : dma_mode_o <= MDMA_MAX;
	endproperty
	property p_mode;
		$changed({udma_sel_o, dma_mode_o, pio_mode_o})
			|-> $past(sf_wr) || $past(sf_wr, 2);
	endproperty
	property p_io16;
		$fell(io16_en_o) |-> $past(sf_wr) || $past(sf_wr, 2);
	endproperty
	property p_apm;
		apm_en_o |-> apm_level_o >= APM_MIN && apm_level_o <= APM_MAX;
	endproperty

	a_ack: assert property (p_ack)
		else $error("ack not a single pulse");
	a_iordy: assert property (p_iordy)
		else $error("iordy off at high pio mode");
	a_fl_hold: assert property (p_fl_hold)
		else $error("flush request dropped early");
	a_fl_drop: assert property (p_fl_drop)
		else $error("flush request kept after done");
	a_pio: assert property (p_pio)
		else $error("pio mode above maximum");
	a_dma: assert property (p_dma)
		else $error("dma mode above maximum");
	a_mode: assert property (p_mode)
		else $error("mode changed without set features");
	a_io16: assert property (p_io16)
		else $error("16-bit indication dropped alone");
	a_apm: assert property (p_apm)
		else $error("power level out of range");
endmodule

bind auss_core auss_core_monitor #(
	.PIO_MAX (PIO_MAX),
	.MDMA_MAX(MDMA_MAX),
	.UDMA_MAX(UDMA_MAX)
) u_mon (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_i, .flush_done_i, .wb_ack_o, .iordy_en_o, .io16_en_o,
	.flush_req_o, .apm_en_o, .apm_level_o, .udma_sel_o, .dma_mode_o,
	.pio_mode_o
);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
// ********************
// command bench
// ********************
module tb_top
	import auss_pkg::*;
;
	localparam logic [31:0] AB  = 32'h0c;
	localparam logic [31:0] IDN = 32'h14;
	logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, flush_done_i;
	logic [5:0]   wb_adr_i;
	logic [3:0]   wb_sel_i;
	logic [31:0]  wb_dat_i, wb_dat_o, rdat, s, s1;
	logic [255:0] user_pw_i, master_pw_i;
	logic         wb_ack_o, iordy_en_o, io16_en_o, wcache_en_o, flush_req_o;
	logic         apm_en_o, udma_sel_o;
	logic [7:0]   apm_level_o, dly;
	logic [2:0]   dma_mode_o, pio_mode_o;
	logic [15:0]  sec [256];
	logic [7:0]   okf [13] = '{8'h69, 8'h96, 8'h97, 8'haa, 8'h55, 8'hcc,
		8'h66, 8'h9a, 8'h09, 8'h89, 8'h0a, 8'h8a, 8'hbb};
	logic [47:0]  sk [4] = '{48'he0_3f_ff_ff_70_00, 48'he0_40_00_00_7f_14,
		48'haf_00_00_01_75_00, 48'ha0_ff_ff_01_7a_14};
	int           mismatches, samples_checked;

	auss_core dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .user_pw_i, .master_pw_i,
		.flush_done_i, .wb_dat_o, .wb_ack_o, .iordy_en_o, .io16_en_o,
		.wcache_en_o, .flush_req_o, .apm_en_o, .apm_level_o, .udma_sel_o,
		.dma_mode_o, .pio_mode_o);
	auss_cache_model u_cache (.clk_i, .rst_i, .flush_req_i(flush_req_o),
		.delay_i(dly), .flush_done_o(flush_done_i));

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		chk({31'h0, wb_ack_o}, 32'h1);
		rdat = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask

	task automatic cmd(input logic [7:0] op);
		int n;
		bus(1'b1, ADR_CMD, {24'h0, op});
		bus(1'b0, ADR_STATUS, 32'h0);
		s1 = rdat;
		if (s1[ST_DRQ] === 1'b1)
			for (int i = 0; i < 256; i++)
				bus(1'b1, ADR_DATA, {16'h0, sec[i]});
		n = 0;
		do
		begin
			bus(1'b0, ADR_STATUS, 32'h0);
			n++;
		end
		while (rdat[ST_BUSY] !== 1'b0 && n < 500);
		s = rdat;
	endtask

	task automatic sf(input logic [7:0] f, input logic [7:0] c);
		bus(1'b1, ADR_FEAT, {24'h0, f});
		bus(1'b1, ADR_SCNT, {24'h0, c});
		cmd(OP_SETFEAT);
	endtask

	task automatic unl(input logic idb, input logic [255:0] pw);
		for (int i = 0; i < 256; i++)
			sec[i] = (i >= 1 && i <= 16) ? pw[(i-1)*16 +: 16] : 16'h0;
		sec[0] = {15'h0, idb};
		cmd(OP_UNLOCK);
	endtask

	function automatic logic [31:0] st(input logic [2:0] c,
		input logic lm, input logic lk, input logic ab);
		return {21'h0, c, 1'b0, lm, lk, 1'b0, ab, ab, 2'b00};
	endfunction

	task automatic t_reset;
		bus(1'b0, ADR_MODE, 32'h0);
		chk(rdat, 32'hff001a00);
		chk({30'h0, iordy_en_o, io16_en_o}, 32'h3);
		bus(1'b0, ADR_STATUS, 32'h0);
		chk(rdat & 32'h77f, st(UNLOCK_INIT, 0, 0, 0));
		$display("done: reset");
	endtask

	task automatic t_xfer;
		for (int m = 0; m <= 4; m++)
		begin
			sf(SF_XFER, {XT_PIO_FC, m[2:0]});
			chk({s[4:0], 1'b0, iordy_en_o, pio_mode_o}, 8 | m);
		end
		sf(SF_XFER, {XT_PIO_FC, 3'h5});
		chk({s[4:0], 1'b0, pio_mode_o}, 32'hc4);
		sf(SF_XFER, {XT_PIO_DEF, XM_NOIORDY});
		chk({s[4:0], iordy_en_o, pio_mode_o}, 32'h0);
		sf(SF_XFER, {XT_PIO_FC, PIO_IORDY});
		chk({s[4:0], iordy_en_o, pio_mode_o}, 32'hb);
		sf(SF_XFER, {XT_PIO_DEF, XM_DEF});
		chk({s[4:0], iordy_en_o, pio_mode_o}, 32'h8);
		for (int m = 0; m <= 2; m++)
		begin
			sf(SF_XFER, {XT_MDMA, m[2:0]});
			chk({s[4:0], udma_sel_o, dma_mode_o}, m);
		end
		sf(SF_XFER, {XT_UDMA, 3'h4});
		chk({s[4:0], udma_sel_o, dma_mode_o}, 32'hc);
		sf(SF_XFER, {XT_UDMA, 3'h5});
		chk(s & 32'h1f, AB);
		sf(SF_XFER, {XT_MDMA, 3'h1});
		chk({s[4:0], udma_sel_o, dma_mode_o}, 32'h1);
		sf(SF_XFER, 8'h10);
		chk({s[4:0], udma_sel_o, dma_mode_o}, 32'hc1);
		$display("done: transfer modes");
	endtask

	task automatic t_feat;
		sf(SF_8BIT_ON, 8'h0);
		chk({31'h0, io16_en_o}, 32'h0);
		sf(SF_8BIT_OFF, 8'h0);
		chk({31'h0, io16_en_o}, 32'h1);
		sf(SF_APM_ON, 8'h00);
		chk(s & 32'h1f, AB);
		sf(SF_APM_ON, APM_MIN);
		chk({23'h0, apm_en_o, apm_level_o}, 32'h101);
		sf(SF_APM_ON, APM_MAX);
		chk({23'h0, apm_en_o, apm_level_o}, 32'h1fe);
		sf(SF_APM_ON, 8'hff);
		chk({s[4:0], apm_en_o, apm_level_o}, 32'h19fe);
		sf(SF_APM_OFF, 8'h0);
		chk({31'h0, apm_en_o}, 32'h0);
		for (int i = 0; i < 13; i++)
		begin
			sf(okf[i], 8'h06);
			chk(s & 32'h1f, 32'h0);
		end
		bus(1'b0, ADR_CYL_LO, 32'h0);
		chk(rdat & 32'hff, 32'h01);
		bus(1'b0, ADR_MODE, 32'h0);
		chk(rdat & 32'hff001800, 32'h06000000);
		sf(8'h42, 8'h0);
		chk(s & 32'h1f, AB);
		$display("done: features");
	endtask

	task automatic t_wcache;
		dly <= 8'd20;
		sf(SF_WC_OFF, 8'h0);
		chk({s1[0], s[4:0], wcache_en_o, flush_req_o}, 32'h80);
		dly <= 8'd0;
		sf(SF_WC_ON, 8'h0);
		chk({31'h0, wcache_en_o}, 32'h1);
		sf(SF_WC_OFF, 8'h0);
		chk({s[4:0], wcache_en_o, flush_req_o}, 32'h0);
		$display("done: write cache");
	endtask

	task automatic t_seek;
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, ADR_DEVHEAD, {24'h0, sk[i][47:40]});
			bus(1'b1, ADR_CYL_HI, {24'h0, sk[i][39:32]});
			bus(1'b1, ADR_CYL_LO, {24'h0, sk[i][31:24]});
			bus(1'b1, ADR_SNUM, {24'h0, sk[i][23:16]});
			cmd(sk[i][15:8]);
			chk(s & 32'h1f, {24'h0, sk[i][7:0]});
		end
		$display("done: seek");
	endtask

	task automatic t_unlock;
		bus(1'b1, ADR_CTRL, 32'h1);
		for (int c = 4; c >= 0; c--)
		begin
			unl(1'b0, ~user_pw_i);
			chk(s & 32'h77f, st(c[2:0], 0, 1, 1));
		end
		unl(1'b0, user_pw_i);
		chk({s1[1], s[10:0] & 11'h77f}, st(0, 0, 1, 1));
		cmd(OP_ERASE);
		chk(s & 32'h1f, AB);
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, ADR_STATUS, 32'h0);
		chk(rdat & 32'h77f, st(UNLOCK_INIT, 0, 0, 0));
		bus(1'b1, ADR_CTRL, 32'h1);
		unl(1'b1, master_pw_i);
		chk({s1[1:0], s[10:0] & 11'h77f}, 32'h1d00);
		bus(1'b1, ADR_CTRL, 32'h1);
		unl(1'b1, ~master_pw_i);
		chk(s & 32'h77f, st(3'h4, 0, 1, 1));
		bus(1'b1, ADR_CTRL, 32'h3);
		unl(1'b1, master_pw_i);
		chk(s & 32'h77f, st(3'h4, 1, 1, 1));
		unl(1'b0, user_pw_i);
		chk(s & 32'h77f, st(3'h4, 1, 0, 0));
		unl(1'b0, ~user_pw_i);
		chk(s & 32'h77f, st(3'h4, 1, 0, 0));
		$display("done: unlock");
	endtask

	task results;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hf;
		rst_i = 1'b1;
		dly = 8'd0;
		user_pw_i = {8{32'h1357_9bdf}};
		master_pw_i = {8{32'h2468_ace0}};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_xfer;
		t_feat;
		t_wcache;
		t_seek;
		t_unlock;
		results;
	end

	initial
	begin
		repeat (60000) @(posedge clk_i);
		mismatches++;
		results;
	end
endmodule
